//--- rtl/pam_port.sv
`timescale 1ns/1ns
module pam_port
#(
    parameter int PINS = pam_pkg::PAM_PINS
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [2:0] reg_sel_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    input wire logic power_down_in,
    input wire logic [4:0] pin_in,
    output logic [4:0] pin_out,
    output logic [4:0] pin_oe_out,
    output logic [4:0] pullup_on_out,
    output logic [3:0] touch_sel_out,
    output logic [3:0] touch_in_out,
    output logic overvoltage_sense_input_out,
    output logic wake_req_out
);
    import pam_pkg::*;

    logic [4:0] port_data_latch_q;
    logic [4:0] port_data_latch_d;
    logic [4:0] pin_direction_bits_q;
    logic [4:0] pin_direction_bits_d;
    logic [4:0] pin_pullup_enable_q;
    logic [4:0] pin_pullup_enable_d;
    logic [4:0] pin_wake_enable_q;
    logic [4:0] pin_wake_enable_d;
    logic [7:0] pin_function_select_a_q;
    logic [7:0] pin_function_select_a_d;
    logic [1:0] pin_function_select_b_q;
    logic [1:0] pin_function_select_b_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [4:0] pin_sync;
    logic [4:0] pin_prev_q;
    logic [4:0] pin_prev_d;
    logic [4:0] oe_q;
    logic [4:0] oe_d;
    logic [4:0] out_q;
    logic [4:0] out_d;
    logic [4:0] pull_q;
    logic [4:0] pull_d;
    logic [3:0] tsel_q;
    logic [3:0] tsel_d;
    logic [3:0] tin_q;
    logic [3:0] tin_d;
    logic ovp_q;
    logic ovp_d;
    logic wake_q;
    logic wake_d;
    logic [4:0] gpio_mode;
    logic [4:0] read_val;
    logic [1:0] f3;
    logic [1:0] f2;
    logic [1:0] f1;
    logic [1:0] f0;
    logic [1:0] f4;

    pam_sync #(.WIDTH(PINS)) u_sync (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    // function decode
    always_comb begin
        f3 = pin_function_select_a_q[PAM_P3_LSB +: 2];
        f2 = pin_function_select_a_q[PAM_P2_LSB +: 2];
        f1 = pin_function_select_a_q[PAM_P1_LSB +: 2];
        f0 = pin_function_select_a_q[PAM_P0_LSB +: 2];
        f4 = pin_function_select_b_q;
        gpio_mode[3] = !f3[1];
        gpio_mode[2] = (f2 != PAM_CODE_ALT);
        gpio_mode[1] = !f1[1];
        gpio_mode[0] = (f0 != PAM_CODE_ALT);
        gpio_mode[4] = (f4 != PAM_CODE_ALT);
        tsel_d[0] = (f0 == PAM_CODE_ALT);
        tsel_d[1] = (f2 == PAM_CODE_ALT);
        tsel_d[2] = (f1 == PAM_CODE_ALT);
        tsel_d[3] = (f3 == PAM_CODE_ALT);
        // touch inputs only see the pin when its key is selected
        tin_d[0] = tsel_d[0] & pin_sync[0];
        tin_d[1] = tsel_d[1] & pin_sync[2];
        tin_d[2] = tsel_d[2] & pin_sync[1];
        tin_d[3] = tsel_d[3] & pin_sync[3];
        // any pin routed to overvoltage sense drives it; low when none
        ovp_d = ((f3 == PAM_CODE_OVP) & pin_sync[3]) |
                ((f1 == PAM_CODE_OVP) & pin_sync[1]) |
                ((f4 == PAM_CODE_ALT) & pin_sync[4]);
    end

    // read mux: inputs show the pin, outputs show the latch
    always_comb begin
        read_val = (pin_direction_bits_q & pin_sync) |
                   (~pin_direction_bits_q & port_data_latch_q);
        rdata_d = rdata_q;
        if (reg_rd_in) begin
            unique case (reg_sel_in)
                PAM_SEL_DATA: rdata_d = {3'h0, read_val};
                PAM_SEL_DIR: rdata_d = {3'h0, pin_direction_bits_q};
                PAM_SEL_PULL: rdata_d = {3'h0, pin_pullup_enable_q};
                PAM_SEL_WAKE: rdata_d = {3'h0, pin_wake_enable_q};
                PAM_SEL_FUNA: rdata_d = pin_function_select_a_q;
                PAM_SEL_FUNB: rdata_d = {6'h00, pin_function_select_b_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // register writes; latch holds until rewritten
    always_comb begin
        port_data_latch_d = port_data_latch_q;
        pin_direction_bits_d = pin_direction_bits_q;
        pin_pullup_enable_d = pin_pullup_enable_q;
        pin_wake_enable_d = pin_wake_enable_q;
        pin_function_select_a_d = pin_function_select_a_q;
        pin_function_select_b_d = pin_function_select_b_q;
        if (reg_wr_in) begin
            unique case (reg_sel_in)
                PAM_SEL_DATA: port_data_latch_d = reg_wdata_in[4:0];
                PAM_SEL_DIR: pin_direction_bits_d = reg_wdata_in[4:0];
                PAM_SEL_PULL: pin_pullup_enable_d = reg_wdata_in[4:0];
                PAM_SEL_WAKE: pin_wake_enable_d = reg_wdata_in[4:0];
                PAM_SEL_FUNA: pin_function_select_a_d = reg_wdata_in;
                PAM_SEL_FUNB: pin_function_select_b_d = reg_wdata_in[1:0];
                default: ;
            endcase
        end
    end

    // pin drive, pull-up and wake
    always_comb begin
        // alternate input functions never drive; software also sets input
        oe_d = ~pin_direction_bits_q & gpio_mode;
        out_d = port_data_latch_q;
        pull_d = pin_pullup_enable_q & pin_direction_bits_q;
        pin_prev_d = pin_sync;
        wake_d = power_down_in &&
                 |(pin_prev_q & ~pin_sync & pin_wake_enable_q & gpio_mode);
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            port_data_latch_q <= PAM_DATA_RST;
            pin_direction_bits_q <= PAM_DIR_RST;
            pin_pullup_enable_q <= PAM_PULL_RST;
            pin_wake_enable_q <= PAM_WAKE_RST;
            pin_function_select_a_q <= PAM_FUNA_RST;
            pin_function_select_b_q <= PAM_FUNB_RST;
            rdata_q <= 8'h00;
            pin_prev_q <= 5'h1f;
            oe_q <= 5'h00;
            out_q <= PAM_DATA_RST;
            pull_q <= 5'h00;
            tsel_q <= 4'h0;
            tin_q <= 4'h0;
            ovp_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            port_data_latch_q <= port_data_latch_d;
            pin_direction_bits_q <= pin_direction_bits_d;
            pin_pullup_enable_q <= pin_pullup_enable_d;
            pin_wake_enable_q <= pin_wake_enable_d;
            pin_function_select_a_q <= pin_function_select_a_d;
            pin_function_select_b_q <= pin_function_select_b_d;
            rdata_q <= rdata_d;
            pin_prev_q <= pin_prev_d;
            oe_q <= oe_d;
            out_q <= out_d;
            pull_q <= pull_d;
            tsel_q <= tsel_d;
            tin_q <= tin_d;
            ovp_q <= ovp_d;
            wake_q <= wake_d;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign pin_out = out_q;
    assign pin_oe_out = oe_q;
    assign pullup_on_out = pull_q;
    assign touch_sel_out = tsel_q;
    assign touch_in_out = tin_q;
    assign overvoltage_sense_input_out = ovp_q;
    assign wake_req_out = wake_q;

    chk_dir_drive: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (reg_wr_in && reg_sel_in == PAM_SEL_DIR && reg_wdata_in[0] && !pin_direction_bits_q[0])
        |=> ##1 !pin_oe_out[0]) else $error("input pin drives");
    chk_dir_read: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (reg_rd_in && reg_sel_in == PAM_SEL_DIR) |=> reg_rdata_out[7:5] == 3'h0)
        else $error("direction upper bits not zero");
    chk_out_read: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (reg_rd_in && reg_sel_in == PAM_SEL_DATA && !pin_direction_bits_q[0])
        |=> reg_rdata_out[0] == $past(port_data_latch_q[0])) else $error("output readback");
    chk_in_read: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (reg_rd_in && reg_sel_in == PAM_SEL_DATA && pin_direction_bits_q[1])
        |=> reg_rdata_out[1] == $past(pin_sync[1])) else $error("input readback");
    chk_touch_four: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        1'b1 |=> touch_sel_out[3] == ($past(pin_function_select_a_q[7:6]) == PAM_CODE_ALT))
        else $error("touch four select");
    chk_touch_two: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        $stable(pin_function_select_a_q[5:4]) |=>
        touch_sel_out[1] == ($past(pin_function_select_a_q[5:4]) == PAM_CODE_ALT))
        else $error("touch two select");
    chk_funb_read: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (reg_rd_in && reg_sel_in == PAM_SEL_FUNB) |=> reg_rdata_out[7:2] == 6'h00)
        else $error("select b upper bits");
    chk_pull_gate: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        pullup_on_out[2] |-> $past(pin_direction_bits_q[2])) else $error("pull-up on output");
    chk_wake_gate: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        wake_req_out |-> $past(power_down_in)) else $error("wake while running");
    chk_latch_hold: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        !(reg_wr_in && reg_sel_in == PAM_SEL_DATA) |=> $stable(port_data_latch_q))
        else $error("latch changed without write");

    // no disable here: these watch the reset itself
    chk_reset_load: assert property (@(posedge sys_clk_in)
        !reset_n_in |=>
        port_data_latch_q == PAM_DATA_RST && pin_direction_bits_q == PAM_DIR_RST)
        else $error("reset did not set data and direction");
    chk_reset_float: assert property (@(posedge sys_clk_in)
        !reset_n_in |=> pin_oe_out == 5'h00 && !wake_req_out)
        else $error("pins driven during reset");

    // two edges after release the flops hold real pin levels
    chk_sync_delay: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        $past(reset_n_in, 2) |-> pin_sync == $past(pin_in, 2))
        else $error("pin level not delayed by two flops");

    chk_dir_write: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (reg_wr_in && reg_sel_in == PAM_SEL_DIR)
        |=> pin_direction_bits_q == $past(reg_wdata_in[4:0]))
        else $error("direction not written");
    chk_data_write: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (reg_wr_in && reg_sel_in == PAM_SEL_DATA)
        |=> port_data_latch_q == $past(reg_wdata_in[4:0]))
        else $error("data latch not written");
    chk_funb_write: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (reg_wr_in && reg_sel_in == PAM_SEL_FUNB)
        |=> pin_function_select_b_q == $past(reg_wdata_in[1:0]))
        else $error("select b not written");
    chk_pull_store: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (reg_wr_in && reg_sel_in == PAM_SEL_PULL)
        |=> pin_pullup_enable_q == $past(reg_wdata_in[4:0]))
        else $error("pull-up enable not written");
    chk_wake_store: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (reg_wr_in && reg_sel_in == PAM_SEL_WAKE)
        |=> pin_wake_enable_q == $past(reg_wdata_in[4:0]))
        else $error("wake enable not written");
    chk_funa_read: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (reg_rd_in && reg_sel_in == PAM_SEL_FUNA) |=> reg_rdata_out == $past(pin_function_select_a_q))
        else $error("select a readback");

    chk_touch_three: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        1'b1 |=> touch_sel_out[2] == ($past(pin_function_select_a_q[3:2]) == PAM_CODE_ALT))
        else $error("touch three select");
    chk_touch_one: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        1'b1 |=> touch_sel_out[0] == ($past(pin_function_select_a_q[1:0]) == PAM_CODE_ALT))
        else $error("touch one select");

    chk_ovp_pin3: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (pin_function_select_a_q[7:6] == PAM_CODE_OVP && pin_sync[3])
        |=> overvoltage_sense_input_out) else $error("pin three overvoltage route");
    chk_ovp_pin1: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (pin_function_select_a_q[3:2] == PAM_CODE_OVP && pin_sync[1])
        |=> overvoltage_sense_input_out) else $error("pin one overvoltage route");
    chk_ovp_pin4: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (pin_function_select_b_q == PAM_CODE_ALT && pin_sync[4])
        |=> overvoltage_sense_input_out) else $error("pin four overvoltage route");
    chk_ovp_idle: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (pin_function_select_a_q[7:6] != PAM_CODE_OVP &&
         pin_function_select_a_q[3:2] != PAM_CODE_OVP &&
         pin_function_select_b_q != PAM_CODE_ALT) |=> !overvoltage_sense_input_out)
        else $error("overvoltage sense without a routed pin");

    chk_wake_alt: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        ((pin_wake_enable_q & gpio_mode) == 5'h00) |=> !wake_req_out)
        else $error("wake from a pin that is not general I/O");

    // a key that is not selected must never see its pad
    for (genvar k = 0; k < 4; k++) begin : g_key_chk
        chk_key_gate: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
            !touch_sel_out[k] |-> !touch_in_out[k]) else $error("unselected touch key sees pad");
    end

    for (genvar i = 0; i < PINS; i++) begin : g_pin_chk
        chk_pin_drive: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
            (!pin_direction_bits_q[i] && gpio_mode[i]) |=> pin_oe_out[i])
            else $error("output pin not driven");
        chk_pin_input: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
            pin_direction_bits_q[i] |=> !pin_oe_out[i]) else $error("input pin driven");
        chk_pin_level: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
            pin_oe_out[i] |-> pin_out[i] == $past(port_data_latch_q[i]))
            else $error("driven level differs from latch");
        chk_pin_pull: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
            (pin_pullup_enable_q[i] && pin_direction_bits_q[i]) |=> pullup_on_out[i])
            else $error("pull-up missing on input");
        chk_pin_wake: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
            (power_down_in && pin_wake_enable_q[i] && gpio_mode[i] &&
             pin_prev_q[i] && !pin_sync[i]) |=> wake_req_out)
            else $error("enabled falling edge missed");
    end

    cov_wake: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in) wake_req_out);
    cov_ovp: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        overvoltage_sense_input_out);
    cov_drive: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in) |pin_oe_out);
    cov_touch: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in) |touch_in_out);
    cov_out_read: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        reg_rd_in && reg_sel_in == PAM_SEL_DATA && !pin_direction_bits_q[1]);
endmodule // pam_port

//--- rtl/pam_pkg.sv
// Notes on behaviour
// - direction bit one makes the pin an input, zero a push-pull output if the pin is general I/O.
// - input pins read back the sampled pin level.
// - output pins read back the output latch, not the pin.
// - direction register bits 4..0 read/write reset one; bits 7..5 read zero.
// - select-a bits 7:6 pick pin3: 0x general, 10 overvoltage sense, 11 touch four.
// - select-a bits 5:4 pick pin2: 11 touch two, else general.
// - select-b bits 1:0 pick pin4: 11 overvoltage sense; bits 7..2 read zero.
// - reset sets all data and direction bits high.
// - falling edge on a wake-enabled pin in power-down raises a wake request.
// - wake enable acts only for general I/O pins while powered down.
// - pull-up enable acts only for input pins; otherwise pull-up is off.
// - output data stays latched until software writes it again.
package pam_pkg;
    localparam int PAM_PINS = 5;
    localparam logic [2:0] PAM_SEL_DATA = 3'h0;
    localparam logic [2:0] PAM_SEL_DIR = 3'h1;
    localparam logic [2:0] PAM_SEL_PULL = 3'h2;
    localparam logic [2:0] PAM_SEL_WAKE = 3'h3;
    localparam logic [2:0] PAM_SEL_FUNA = 3'h4;
    localparam logic [2:0] PAM_SEL_FUNB = 3'h5;
    localparam logic [4:0] PAM_DATA_RST = 5'h1f;
    localparam logic [4:0] PAM_DIR_RST = 5'h1f;
    localparam logic [4:0] PAM_PULL_RST = 5'h00;
    localparam logic [4:0] PAM_WAKE_RST = 5'h00;
    localparam logic [7:0] PAM_FUNA_RST = 8'h00;
    localparam logic [1:0] PAM_FUNB_RST = 2'h0;
    localparam logic [1:0] PAM_CODE_ALT = 2'h3;
    localparam logic [1:0] PAM_CODE_OVP = 2'h2;
    localparam int PAM_P3_LSB = 6;
    localparam int PAM_P2_LSB = 4;
    localparam int PAM_P1_LSB = 2;
    localparam int PAM_P0_LSB = 0;
endpackage

//--- rtl/pam_sync.sv
`timescale 1ns/1ns
module pam_sync #(
    parameter int WIDTH = 5
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // first stage feeds only the second
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // resets high to match idle pulled-up pins, avoiding a false fall
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            meta_q <= {WIDTH{1'b1}};
            sync_q <= {WIDTH{1'b1}};
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule // pam_sync

//--- sim/pam_board.sv
`timescale 1ns/1ns
module pam_board (
    input wire logic sys_clk_in,
    input wire logic [4:0] drive_in,
    input wire logic [4:0] drive_oe_in,
    input wire logic [4:0] pullup_in,
    input wire logic [4:0] ext_en_in,
    input wire logic [4:0] ext_val_in,
    output logic [4:0] pad_out
);
    logic [4:0] last_q = 5'h00;
    // a floating pad wanders: show the inverse of its last level
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            if (drive_oe_in[i]) pad_out[i] = drive_in[i];
            else if (ext_en_in[i]) pad_out[i] = ext_val_in[i];
            else if (pullup_in[i]) pad_out[i] = 1'b1;
            else pad_out[i] = ~last_q[i];
        end
    end
    always_ff @(posedge sys_clk_in) last_q <= pad_out;
endmodule // pam_board

//--- sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import pam_pkg::*;
    logic sys_clk = 1'b0, reset_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, pd = 1'b0;
    logic [2:0] sel = 3'h0;
    logic [7:0] wdata = 8'h00, rdata, v;
    logic [4:0] pad, pin_drv, pin_oe, pull, ext_val = 5'h15;
    logic [3:0] tsel, tin;
    logic ovp, wake;
    int error_cnt = 0, n_checks = 0, c;
    always #2 sys_clk = ~sys_clk;
    pam_port dut (.sys_clk_in(sys_clk), .reset_n_in(reset_n), .reg_sel_in(sel),
        .reg_wr_in(wr_en), .reg_rd_in(rd_en), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .power_down_in(pd), .pin_in(pad), .pin_out(pin_drv), .pin_oe_out(pin_oe),
        .pullup_on_out(pull), .touch_sel_out(tsel), .touch_in_out(tin),
        .overvoltage_sense_input_out(ovp), .wake_req_out(wake));
    pam_board board (.sys_clk_in(sys_clk), .drive_in(pin_drv), .drive_oe_in(pin_oe),
        .pullup_in(pull), .ext_en_in(5'h1f), .ext_val_in(ext_val), .pad_out(pad));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        @(posedge sys_clk) begin sel <= s; wdata <= d; wr_en <= 1'b1; end
        @(posedge sys_clk) wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] s, output logic [7:0] d);
        @(posedge sys_clk) begin sel <= s; rd_en <= 1'b1; end
        @(posedge sys_clk) rd_en <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // set the new pad level, then count one-cycle wake pulses over the next 8 cycles, two-flop synchroniser delay included
    task automatic fall_count(input logic [4:0] lvl, output int cnt);
        cnt = 0;
        @(posedge sys_clk) ext_val <= lvl;
        repeat (8) begin
            cyc(1);
            if (wake === 1'b1) cnt++;
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #40000;
        error_cnt++;
        stop_test();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        cyc(4);
        rd(PAM_SEL_DIR, v); chk(v, 8'h1f);
        rd(PAM_SEL_DATA, v); chk(v, 8'h15);
        chk({3'h0, pin_oe}, 8'h00);
        chk({3'h0, pin_drv}, 8'h1f);
        rd(PAM_SEL_FUNA, v); chk(v, 8'h00);
        rd(PAM_SEL_FUNB, v); chk(v, 8'h00);
        $display("test reset values done");
        wr(PAM_SEL_DIR, 8'hff); rd(PAM_SEL_DIR, v); chk(v, 8'h1f);
        wr(PAM_SEL_FUNB, 8'hff); rd(PAM_SEL_FUNB, v); chk(v, 8'h03);
        wr(PAM_SEL_FUNA, 8'ha5); rd(PAM_SEL_FUNA, v); chk(v, 8'ha5);
        wr(3'h6, 8'hff); rd(3'h6, v); chk(v, 8'h00);
        wr(PAM_SEL_FUNA, 8'h00);
        wr(PAM_SEL_FUNB, 8'h00);
        $display("test register access done");
        wr(PAM_SEL_DIR, 8'h1c);
        cyc(2);
        chk({3'h0, pin_oe}, 8'h03);
        chk({3'h0, pin_drv}, 8'h1f);
        wr(PAM_SEL_DATA, 8'h0a);
        cyc(2);
        chk({6'h00, pin_drv[1:0]}, 8'h02);
        rd(PAM_SEL_DATA, v); chk(v, 8'h16);
        wr(PAM_SEL_PULL, 8'h1f); rd(PAM_SEL_PULL, v); chk(v, 8'h1f);
        cyc(3);
        chk({3'h0, pull}, 8'h1c);
        rd(PAM_SEL_DIR, v);
        wr(PAM_SEL_DIR, v | 8'h01);
        cyc(2);
        chk({3'h0, pin_oe}, 8'h02);
        chk({7'h00, pin_drv[1]}, 8'h01);
        wr(PAM_SEL_DIR, 8'h1f);
        wr(PAM_SEL_PULL, 8'h00);
        $display("test output path done");
        ext_val <= 5'h1a;
        for (int k = 0; k < 4; k++) begin
            wr(PAM_SEL_FUNA, {4{k[1:0]}});
            wr(PAM_SEL_FUNB, {6'h00, k[1:0]});
            cyc(4);
            chk({4'h0, tsel}, (k == 3) ? 8'h0f : 8'h00);
            chk({4'h0, tin}, (k == 3) ? 8'h0c : 8'h00);
            chk({7'h00, ovp}, (k >= 2) ? 8'h01 : 8'h00);
        end
        wr(PAM_SEL_FUNA, 8'h00);
        wr(PAM_SEL_FUNB, 8'h00);
        $display("test pin function select done");
        ext_val <= 5'h1f;
        wr(PAM_SEL_WAKE, 8'h01); rd(PAM_SEL_WAKE, v); chk(v, 8'h01);
        @(posedge sys_clk) pd <= 1'b1;
        cyc(4);
        fall_count(5'h1e, c); chk(c[7:0], 8'h01);
        fall_count(5'h1f, c); chk(c[7:0], 8'h00);
        @(posedge sys_clk) pd <= 1'b0;
        fall_count(5'h1e, c); chk(c[7:0], 8'h00);
        fall_count(5'h1f, c);
        @(posedge sys_clk) pd <= 1'b1;
        wr(PAM_SEL_FUNA, 8'h03);
        fall_count(5'h1e, c); chk(c[7:0], 8'h00);
        $display("test wake-up done");
        stop_test();
    end
endmodule // tb_top
